// >>> design/rate_sample_counter_cmd.sv
// Command driven two channel counter with rate sampling
// Notes on behaviour
// R01: Configure command has high byte 01.
// R02: Config word 1 bit 12 selects rate mode.
// R03: Word 1000: pulse, rate on, outputs off.
// R04: Load 0243: ch2 off, ch1 preset, enabled.
// R05: Rate mode: load words give periods ms.
// R06: Rate read is 0400; other words ignored.
// R07: Rate equals counts over sample period.
// R08: First response word echoes the executed command's high byte, low byte zero.
// R09: Rate split as high*65536 plus low.
// R10: Disabled second channel returns zero words.
// R11: Sixth word holds field power digit only.
// R12: Encoder bit set: count all quadrature edges.
// R13: Encoder bit clear: one count per pulse.
// R14: Bus activity indicator follows host link.
// R15: Fault indicator on fuse or supply loss.
// R16: Per channel count, enable, preset and output reset input indicators.
// R17: Count only while enable input is low.
// R18: Low preset input loads preset value.
// R19: Boundary latches rate, clears, restarts period.
`timescale 1ns/100ps
module rate_sample_counter_cmd #(
	parameter int CYC_PER_MS = rate_counter_pkg::CYC_PER_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	// Host link and module health
	input wire logic host_link_ok,
	input wire logic fuse_blown,
	input wire logic out_supply_lost,
	input wire logic field_power_ok,
	// Channel 1 field inputs
	input wire logic ch1_count_in,
	input wire logic ch1_phase_b_in,
	input wire logic ch1_enable_n,
	input wire logic ch1_preset_n,
	input wire logic ch1_out_reset_n,
	// Channel 2 field inputs
	input wire logic ch2_count_in,
	input wire logic ch2_phase_b_in,
	input wire logic ch2_enable_n,
	input wire logic ch2_preset_n,
	input wire logic ch2_out_reset_n,
	// Front indicators
	output logic bus_active_indicator,
	output logic fault_indicator,
	output logic ch1_count_indicator,
	output logic ch1_enable_indicator,
	output logic ch1_preset_indicator,
	output logic ch1_reset_indicator,
	output logic ch2_count_indicator,
	output logic ch2_enable_indicator,
	output logic ch2_preset_indicator,
	output logic ch2_reset_indicator,
	// Field outputs
	output logic ch1_first_output,
	output logic ch1_second_output,
	output logic ch2_first_output,
	output logic ch2_second_output
);
	if (CYC_PER_MS < 1 || CYC_PER_MS > 16777215) begin : g_bad_tick
		$error("CYC_PER_MS out of range");
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	// Field inputs gathered per channel
	wire [1:0] in_a = {ch2_count_in, ch1_count_in};
	wire [1:0] in_b = {ch2_phase_b_in, ch1_phase_b_in};
	wire [1:0] in_en_n = {ch2_enable_n, ch1_enable_n};
	wire [1:0] in_pre_n = {ch2_preset_n, ch1_preset_n};
	wire [1:0] in_res_n = {ch2_out_reset_n, ch1_out_reset_n};

	logic [15:0] cmd_ff [6], resp_ff [6];
	logic [1:0] enc_ff;
	logic rate_mode_ff, hold_ff;
	logic [23:0] tick_cnt_ff;
	logic [rate_counter_pkg::IRQ_W-1:0] irq_stat_ff, irq_en_ff;
	logic irq_ff, fault_ff, bus_active_ff;
	logic [15:0] rdata_ff;
	// Address decode
	wire [2:0] widx = reg_addr[2:0];
	wire word_ok = widx <= rate_counter_pkg::LAST_WORD;
	wire cmd_hit = reg_addr[4:3] == rate_counter_pkg::ADDR_CMD0[4:3] &&
		word_ok;
	wire resp_hit = reg_addr[4:3] == rate_counter_pkg::ADDR_RESP0[4:3] &&
		word_ok;
	wire wr_cmd = reg_wr & cmd_hit;
	wire wr_cmd0 = reg_wr & (reg_addr == rate_counter_pkg::ADDR_CMD0);
	wire wr_clr = reg_wr & (reg_addr == rate_counter_pkg::ADDR_IRQ_CLR);
	wire wr_en = reg_wr & (reg_addr == rate_counter_pkg::ADDR_IRQ_EN);

	// Writing word 0 launches the command; words 1..5 must be written first
	wire [7:0] op = reg_wdata[15:8];
	wire [7:0] cmd_low = reg_wdata[7:0];
	wire exec_cfg = wr_cmd0 & (op == rate_counter_pkg::OP_CONFIG); // see R01
	wire exec_load = wr_cmd0 & (op == rate_counter_pkg::OP_LOAD);
	wire exec_cnt = wr_cmd0 & (op == rate_counter_pkg::OP_READ_COUNT);
	wire exec_rate = wr_cmd0 & (op == rate_counter_pkg::OP_READ_RATE);
	wire exec_any = exec_cfg | exec_load | exec_cnt | exec_rate;

	// Millisecond tick shared by both channels
	wire tick_ms = tick_cnt_ff == 24'(CYC_PER_MS - 1);
	// Outputs fall when the host link drops unless told to hold
	wire kill_out = ~host_link_ok & ~hold_ff; // see R03

	wire [1:0] boundary, ch_on;
	wire [31:0] rate_w [2], accum_w [2];
	for (genvar c = 0; c < rate_counter_pkg::NUM_CH; c++) begin : g_ch
		logic a_q, b_q, on_ff;
		logic [15:0] period_ff, ms_cnt_ff;
		logic [31:0] accum_ff, rate_ff;
		logic out_a_ff, out_b_ff;
		logic cnt_ind_ff, en_ind_ff, pre_ind_ff, res_ind_ff;
		wire en_bit = cmd_low[rate_counter_pkg::CB_ENABLE_POS +
			rate_counter_pkg::CB_CH_STRIDE * c];
		wire pre_bit = cmd_low[rate_counter_pkg::CB_PRESET_POS +
			rate_counter_pkg::CB_CH_STRIDE * c];
		wire dis_bit = cmd_low[rate_counter_pkg::CB_DISABLE_POS + c];
		wire do_dis = (exec_cfg | exec_load) & dis_bit; // see R04
		wire nxt_on = do_dis ? 1'b0 : ((exec_load & en_bit) ? 1'b1 : on_ff);
		wire cmd_preset = exec_load & pre_bit; // see R04
		// Zero period words mean no change
		wire [15:0] new_period = cmd_ff[1 + c];
		wire take_period = exec_load & rate_mode_ff &
			(new_period != 16'h0000); // see R05
		wire [15:0] nxt_period = take_period ? new_period : period_ff;

		// Quadrature counts both phases, pulse counts rising A only
		wire rise_a = in_a[c] & ~a_q;
		wire edge_ab = (in_a[c] ^ a_q) | (in_b[c] ^ b_q);
		wire hit = enc_ff[c] ? edge_ab : rise_a; // see R12 R13
		wire counting = on_ff & ~in_en_n[c] & hit; // see R17
		wire [31:0] inc_accum = accum_ff + {31'h0000_0000, counting};
		wire preset_now = ~in_pre_n[c] | cmd_preset; // see R18
		// A period shortened below the running count ends at the next tick
		wire ms_end = tick_ms & (ms_cnt_ff >= period_ff - 16'h0001);
		wire run = rate_mode_ff & on_ff; // see R02
		wire bnd = run & ms_end;
		wire [15:0] nxt_ms = (!run) ? 16'h0000 :
			(tick_ms ? (ms_end ? 16'h0000 : ms_cnt_ff + 16'h0001) :
			ms_cnt_ff);
		// Count reaching past 16 bits in one period lights output B
		wire big = inc_accum[31:16] != 16'h0000;

		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				a_q <= 1'b0;
				b_q <= 1'b0;
				on_ff <= rate_counter_pkg::CH_ON_RST;
				period_ff <= rate_counter_pkg::PERIOD_RST;
				ms_cnt_ff <= 16'h0000;
				accum_ff <= 32'h0000_0000;
				rate_ff <= 32'h0000_0000;
			end else begin
				a_q <= in_a[c];
				b_q <= in_b[c];
				on_ff <= nxt_on;
				period_ff <= nxt_period;
				ms_cnt_ff <= nxt_ms; // see R19
				if (preset_now) begin
					accum_ff <= rate_counter_pkg::PRESET_VAL; // see R18
				end else if (bnd) begin
					accum_ff <= 32'h0000_0000; // see R19
				end else begin
					accum_ff <= inc_accum; // see R07
				end
				if (bnd) begin
					rate_ff <= inc_accum; // see R07 R19
				end
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				out_a_ff <= 1'b0;
				out_b_ff <= 1'b0;
			end else if (kill_out || !in_res_n[c]) begin
				out_a_ff <= 1'b0; // see R03
				out_b_ff <= 1'b0;
			end else if (bnd) begin
				out_a_ff <= 1'b1;
				out_b_ff <= out_b_ff | big;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_b) begin
				cnt_ind_ff <= 1'b0;
				en_ind_ff <= 1'b0;
				pre_ind_ff <= 1'b0;
				res_ind_ff <= 1'b0;
			end else begin
				cnt_ind_ff <= in_a[c]; // see R16
				en_ind_ff <= ~in_en_n[c];
				pre_ind_ff <= ~in_pre_n[c];
				res_ind_ff <= ~in_res_n[c];
			end
		end

		assign boundary[c] = bnd;
		assign ch_on[c] = on_ff;
		assign rate_w[c] = rate_ff;
		assign accum_w[c] = accum_ff;
	end

	// Response words for each command
	wire [15:0] echo = {op, 8'h00}; // see R08
	wire [31:0] sel1 = !ch_on[0] ? 32'h0000_0000 :
		exec_rate ? rate_w[0] : accum_w[0];
	wire [31:0] sel2 = !ch_on[1] ? 32'h0000_0000 : // see R10
		exec_rate ? rate_w[1] : accum_w[1];
	wire [15:0] pwr_word = 16'({3'h0, field_power_ok}) <<
		rate_counter_pkg::PWR_DIGIT_POS; // see R11
	wire read_any = exec_rate | exec_cnt; // see R06

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			for (int i = 0; i < 6; i++) begin
				cmd_ff[i] <= 16'h0000;
				resp_ff[i] <= 16'h0000;
			end
		end else begin
			if (wr_cmd) begin
				cmd_ff[widx] <= reg_wdata;
			end
			if (exec_any) begin
				resp_ff[0] <= echo; // see R08
			end
			if (read_any) begin
				resp_ff[1] <= sel1[15:0]; // see R09
				resp_ff[2] <= sel1[31:16];
				resp_ff[3] <= sel2[15:0]; // see R10
				resp_ff[4] <= sel2[31:16];
				resp_ff[5] <= pwr_word; // see R11
			end else if (exec_cfg || exec_load) begin
				for (int i = 1; i < 6; i++) begin
					resp_ff[i] <= cmd_ff[i];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			enc_ff <= 2'h0;
			rate_mode_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else if (exec_cfg) begin
			enc_ff <= cmd_ff[1][rate_counter_pkg::CFG_ENC_POS +: 2]; // see R12
			rate_mode_ff <= cmd_ff[1][rate_counter_pkg::CFG_RATE_POS]; // see R02
			hold_ff <= cmd_ff[1][rate_counter_pkg::CFG_HOLD_POS]; // see R03
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tick_cnt_ff <= 24'h00_0000;
		end else begin
			tick_cnt_ff <= tick_ms ? 24'h00_0000 : tick_cnt_ff + 24'h00_0001;
		end
	end

	// Interrupts: set wins over a clear in the same cycle
	wire fault_now = fuse_blown | out_supply_lost;
	wire [rate_counter_pkg::IRQ_W-1:0] irq_ev =
		{fault_now & ~fault_ff, boundary, exec_any};
	wire [rate_counter_pkg::IRQ_W-1:0] irq_clr =
		wr_clr ? reg_wdata[rate_counter_pkg::IRQ_W-1:0] : 4'h0;
	wire [rate_counter_pkg::IRQ_W-1:0] nxt_irq_stat =
		(irq_stat_ff & ~irq_clr) | irq_ev;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			irq_stat_ff <= 4'h0;
			irq_en_ff <= rate_counter_pkg::IRQ_EN_RST;
			irq_ff <= 1'b0;
			fault_ff <= 1'b0;
			bus_active_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			if (wr_en) begin
				irq_en_ff <= reg_wdata[rate_counter_pkg::IRQ_W-1:0];
			end
			irq_ff <= |(nxt_irq_stat & (wr_en ?
				reg_wdata[rate_counter_pkg::IRQ_W-1:0] : irq_en_ff));
			fault_ff <= fault_now; // see R15
			bus_active_ff <= host_link_ok; // see R14
		end
	end

	// Read mux; unmapped words and the clear register read zero
	wire [15:0] status_word = {10'h000, rate_mode_ff, hold_ff, ch_on,
		fault_ff, bus_active_ff};
	wire [15:0] rd_mux =
		cmd_hit ? cmd_ff[widx] :
		resp_hit ? resp_ff[widx] :
		(reg_addr == rate_counter_pkg::ADDR_IRQ_STAT) ?
			{12'h000, irq_stat_ff} :
		(reg_addr == rate_counter_pkg::ADDR_IRQ_EN) ?
			{12'h000, irq_en_ff} :
		(reg_addr == rate_counter_pkg::ADDR_STATUS) ? status_word :
		16'h0000;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq = irq_ff;
	assign bus_active_indicator = bus_active_ff;
	assign fault_indicator = fault_ff;
	assign ch1_count_indicator = g_ch[0].cnt_ind_ff;
	assign ch1_enable_indicator = g_ch[0].en_ind_ff;
	assign ch1_preset_indicator = g_ch[0].pre_ind_ff;
	assign ch1_reset_indicator = g_ch[0].res_ind_ff;
	assign ch2_count_indicator = g_ch[1].cnt_ind_ff;
	assign ch2_enable_indicator = g_ch[1].en_ind_ff;
	assign ch2_preset_indicator = g_ch[1].pre_ind_ff;
	assign ch2_reset_indicator = g_ch[1].res_ind_ff;
	assign ch1_first_output = g_ch[0].out_a_ff;
	assign ch1_second_output = g_ch[0].out_b_ff;
	assign ch2_first_output = g_ch[1].out_a_ff;
	assign ch2_second_output = g_ch[1].out_b_ff;

	// Command sequences
	sequence s_cfg_req;
		reg_wr && reg_addr == rate_counter_pkg::ADDR_CMD0 &&
			reg_wdata[15:8] == rate_counter_pkg::OP_CONFIG;
	endsequence
	sequence s_load_0243;
		reg_wr && reg_addr == rate_counter_pkg::ADDR_CMD0 &&
			reg_wdata == 16'h0243;
	endsequence
	sequence s_rate_req;
		reg_wr && reg_addr == rate_counter_pkg::ADDR_CMD0 &&
			reg_wdata == 16'h0400;
	endsequence

	chk_cfg_echo: assert property (s_cfg_req |=> // see R01 R08
		resp_ff[0] == 16'h0100) else $error("config echo wrong");
	chk_rate_mode_bit: assert property (s_cfg_req |=> // see R02
		rate_mode_ff == $past(cmd_ff[1][rate_counter_pkg::CFG_RATE_POS]))
		else $error("rate mode not taken");
	chk_load_0243: assert property (s_load_0243 |=> // see R04
		!ch_on[1] && ch_on[0] &&
		accum_w[0] == rate_counter_pkg::PRESET_VAL)
		else $error("load 0243 wrong");
	chk_period_take: assert property ( // see R05
		s_load_0243 ##0 (rate_mode_ff && cmd_ff[1] != 16'h0000) |=>
		g_ch[0].period_ff == $past(cmd_ff[1]))
		else $error("period not loaded");
	chk_rate_echo: assert property (s_rate_req |=> // see R06 R08
		resp_ff[0] == 16'h0400) else $error("rate echo wrong");
	chk_rate_split: assert property (s_rate_req ##0 ch_on[0] |=> // see R09
		{resp_ff[2], resp_ff[1]} == $past(rate_w[0]))
		else $error("rate words wrong");
	chk_ch2_zero: assert property (s_rate_req ##0 !ch_on[1] |=> // see R10
		resp_ff[3] == 16'h0000 && resp_ff[4] == 16'h0000)
		else $error("disabled channel not zero");
	chk_power_word: assert property (s_rate_req |=> // see R11
		resp_ff[5][15:9] == 7'h00 && resp_ff[5][7:0] == 8'h00 &&
		resp_ff[5][8] == $past(field_power_ok))
		else $error("power word wrong");
	chk_sample_latch: assert property (boundary[0] |=> // see R19 R07
		rate_w[0] == $past(g_ch[0].inc_accum) &&
		accum_w[0] == 32'h0000_0000) else $error("sample latch wrong");
	chk_quad_edges: assert property ( // see R12
		ch_on[0] && enc_ff[0] && !ch1_enable_n &&
		(ch1_phase_b_in != g_ch[0].b_q) && !boundary[0] &&
		!g_ch[0].preset_now |=> accum_w[0] == $past(accum_w[0]) + 32'h1)
		else $error("quadrature edge missed");
	chk_hold_disabled: assert property ( // see R17
		ch1_enable_n && !boundary[0] && !g_ch[0].preset_now |=>
		$stable(accum_w[0])) else $error("counted while disabled");
	chk_outputs_off: assert property (kill_out |=> // see R03
		!ch1_first_output && !ch1_second_output &&
		!ch2_first_output && !ch2_second_output)
		else $error("outputs on after link loss");
	chk_fault_led: assert property ( // see R15
		(fuse_blown || out_supply_lost) |=> fault_indicator)
		else $error("fault indicator missing");
endmodule // rate_sample_counter_cmd

// >>> common/rate_counter_pkg.sv
// Constants shared by the rate sample counter design
package rate_counter_pkg;
	// Channels and word width
	localparam int NUM_CH = 2;
	localparam int WORD_W = 16;

	// Register word indices on the plain register port
	localparam logic [4:0] ADDR_CMD0 = 5'h00;
	localparam logic [4:0] ADDR_RESP0 = 5'h08;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
	localparam logic [4:0] ADDR_IRQ_CLR = 5'h11;
	localparam logic [4:0] ADDR_IRQ_EN = 5'h12;
	localparam logic [4:0] ADDR_STATUS = 5'h13;
	localparam logic [2:0] LAST_WORD = 3'h5;

	// Command opcodes in the high byte of command word 0
	localparam logic [7:0] OP_CONFIG = 8'h01;
	localparam logic [7:0] OP_LOAD = 8'h02;
	localparam logic [7:0] OP_READ_COUNT = 8'h03;
	localparam logic [7:0] OP_READ_RATE = 8'h04;

	// Low byte of command word 0, channel c enable and preset at offset c*stride, disable at pos+c
	localparam int CB_ENABLE_POS = 0;
	localparam int CB_PRESET_POS = 1;
	localparam int CB_CH_STRIDE = 2;
	localparam int CB_DISABLE_POS = 5;

	// Configuration word 1 fields, channel c encoder bit at pos+c
	localparam int CFG_ENC_POS = 8;
	localparam int CFG_HOLD_POS = 10;
	localparam int CFG_RATE_POS = 12;

	// Sixth response word: field power digit position
	localparam int PWR_DIGIT_POS = 8;

	// Interrupt status layout
	localparam int IRQ_W = 4;
	localparam int IRQ_CMD_POS = 0;
	localparam int IRQ_SAMPLE_POS = 1;
	localparam int IRQ_FAULT_POS = 3;

	// Values after reset, and the preset load value
	localparam logic [15:0] PERIOD_RST = 16'h03E8;
	localparam logic [31:0] PRESET_VAL = 32'h0000_0000;
	localparam logic CH_ON_RST = 1'b1;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

	// Sample time unit and clock
	localparam int MS_NS = 1000000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
endpackage

// >>> tb/field_encoder_model.sv
// Field encoder model feeding one counter channel
`timescale 1ns/100ps
module field_encoder_model (
	// Clock
	input wire logic clk_sys,
	// Mode
	input wire logic run,
	input wire logic quad,
	// Encoder lines
	output logic phase_a,
	output logic phase_b
);
	logic [1:0] step_ff = 2'h0;

	// Lines stand still while stopped
	always_ff @(posedge clk_sys) begin
		if (run) begin
			step_ff <= step_ff + 2'h1;
		end
	end
	// Gray order in quadrature, so one line moves per step
	assign phase_a = step_ff[1];
	assign phase_b = quad ? (step_ff[1] ^ step_ff[0]) : 1'b1;
endmodule // field_encoder_model

// >>> tb/rate_sample_counter_cmd_bench.sv
// Self-checking bench for the rate sample counter
`timescale 1ns/100ps
module rate_sample_counter_cmd_bench;
	localparam int CYC = 10;
	logic clk_sys, rst_b, reg_wr, reg_rd, irq;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic host_link_ok, fuse_blown, out_supply_lost, field_power_ok;
	logic [1:0] en_n, pre_n, ores_n, cnt, phb, cnt_ind, run;
	logic [7:0] ind;
	logic [8:0] v;
	logic o1a, o1b, o2a, o2b, quad1;
	logic [15:0] exp_q[$];
	logic [15:0] words[6];
	int errors, compares, model_rate;

	rate_sample_counter_cmd #(.CYC_PER_MS(CYC)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.host_link_ok(host_link_ok), .fuse_blown(fuse_blown),
		.out_supply_lost(out_supply_lost), .field_power_ok(field_power_ok),
		.ch1_count_in(cnt[0]), .ch1_phase_b_in(phb[0]),
		.ch1_enable_n(en_n[0]), .ch1_preset_n(pre_n[0]),
		.ch1_out_reset_n(ores_n[0]),
		.ch2_count_in(cnt[1]), .ch2_phase_b_in(phb[1]),
		.ch2_enable_n(en_n[1]), .ch2_preset_n(pre_n[1]),
		.ch2_out_reset_n(ores_n[1]),
		.bus_active_indicator(ind[7]), .fault_indicator(ind[6]),
		.ch1_count_indicator(cnt_ind[0]), .ch1_enable_indicator(ind[5]),
		.ch1_preset_indicator(ind[4]), .ch1_reset_indicator(ind[3]),
		.ch2_count_indicator(cnt_ind[1]), .ch2_enable_indicator(ind[2]),
		.ch2_preset_indicator(ind[1]), .ch2_reset_indicator(ind[0]),
		.ch1_first_output(o1a), .ch1_second_output(o1b),
		.ch2_first_output(o2a), .ch2_second_output(o2b)
	);
	field_encoder_model enc1 (.clk_sys(clk_sys), .run(run[0]),
		.quad(quad1), .phase_a(cnt[0]), .phase_b(phb[0]));
	field_encoder_model enc2 (.clk_sys(clk_sys), .run(run[1]),
		.quad(1'b0), .phase_a(cnt[1]), .phase_b(phb[1]));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic final_report();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] e,
			input logic [15:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] w);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] r);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		r = reg_rdata;
	endtask

	// Writes a block, predicts the response and reads it back
	task automatic command(input logic [15:0] w0, input logic [15:0] w1,
			input logic [15:0] w2);
		logic [15:0] r;
		logic pwr;
		words[1] = w1;
		words[2] = w2;
		for (int i = 3; i < 6; i++) words[i] = 16'($urandom);
		for (int i = 1; i < 6; i++) wr(5'(i), words[i]);
		pwr = 1'($urandom);
		field_power_ok <= pwr;
		wr(rate_counter_pkg::ADDR_CMD0, w0);
		if (w0[15:8] == 8'h01 || w0[15:8] == 8'h02) begin
			exp_q.push_back({w0[15:8], 8'h00});
			for (int i = 1; i < 6; i++) exp_q.push_back(words[i]);
		end else begin
			exp_q.push_back(w0);
			exp_q.push_back(model_rate[15:0]);
			exp_q.push_back(model_rate[31:16]);
			exp_q.push_back(16'h0000);
			exp_q.push_back(16'h0000);
			exp_q.push_back({7'h00, pwr, 8'h00});
		end
		for (int i = 0; i < 6; i++) begin
			rd(rate_counter_pkg::ADDR_RESP0 + 5'(i), r);
			check($sformatf("response word %0d", i), exp_q.pop_front(), r);
		end
	endtask

	task automatic wait_sample();
		logic [15:0] s;
		wr(rate_counter_pkg::ADDR_IRQ_CLR, 16'h0002);
		s = 16'h0000;
		for (int n = 0; n < 100 && s[1] !== 1'b1; n++) begin
			rd(rate_counter_pkg::ADDR_IRQ_STAT, s);
		end
		check("sample flag", 16'h0002, s & 16'h0002);
	endtask

	// Two boundaries after loading, so the read covers a whole period
	task automatic rate_run(input logic [15:0] cfg, input logic q,
			input int r);
		quad1 <= q;
		command(16'h0140, cfg, 16'h0000);
		command(16'h0243, 16'h0002, 16'h0000);
		wait_sample();
		wait_sample();
		model_rate = r;
		command(16'h0400, 16'($urandom), 16'($urandom));
	endtask

	initial begin
		#(4 * 30000);
		errors++;
		final_report();
	end

	initial begin
		void'($urandom(32'hE3290256));
		rst_b = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{host_link_ok, fuse_blown, out_supply_lost} = 3'h4;
		field_power_ok = 1'b1;
		en_n = 2'h0;
		pre_n = 2'h3;
		ores_n = 2'h3;
		run = 2'h3;
		quad1 = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(rate_counter_pkg::ADDR_IRQ_EN, d);
		check("irq enable reset", 16'h0000, d);
		// 20 cycle period: 5 pulses, or 20 quadrature edges
		rate_run(16'h1000, 1'b0, 5);
		check("first output", 16'h0001, {15'h0000, o1a});
		@(posedge clk_sys);
		host_link_ok <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		check("outputs off", 16'h0000,
			{12'h000, o1a, o1b, o2a, o2b});
		@(posedge clk_sys);
		host_link_ok <= 1'b1;
		rate_run(16'h1000, 1'b1, 5);
		rate_run(16'h1100, 1'b1, 20);
		@(posedge clk_sys);
		en_n[0] <= 1'b1;
		rate_run(16'h1100, 1'b1, 0);
		// Rate mode off so the count builds up, then freeze and preset it
		command(16'h0140, 16'h0000, 16'h0000);
		@(posedge clk_sys);
		en_n[0] <= 1'b0;
		repeat (8) @(posedge clk_sys);
		run[0] <= 1'b0;
		pre_n[0] <= 1'b0;
		repeat (2) @(posedge clk_sys);
		pre_n[0] <= 1'b1;
		model_rate = 0;
		command(16'h0300, 16'h0000, 16'h0000);
		// Interrupt raise, clear and mask
		wr(rate_counter_pkg::ADDR_IRQ_CLR, 16'h000F);
		wr(rate_counter_pkg::ADDR_IRQ_EN, 16'h0001);
		command(16'h0400, 16'h0000, 16'h0000);
		check("irq raised", 16'h0001, {15'h0000, irq});
		wr(rate_counter_pkg::ADDR_IRQ_CLR, 16'h0001);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("irq cleared", 16'h0000, {15'h0000, irq});
		wr(rate_counter_pkg::ADDR_IRQ_EN, 16'h0000);
		command(16'h0400, 16'h0000, 16'h0000);
		check("irq masked", 16'h0000, {15'h0000, irq});
		rd(rate_counter_pkg::ADDR_IRQ_STAT, d);
		check("done status", 16'h0001, d & 16'h0001);
		rd(5'h1F, d);
		check("unmapped read", 16'h0000, d);
		wr(rate_counter_pkg::ADDR_RESP0, 16'hFFFF);
		rd(rate_counter_pkg::ADDR_RESP0, d);
		check("read-only word", 16'h0400, d);
		@(posedge clk_sys);
		en_n[0] <= 1'b0;
		run <= 2'h0;
		for (int n = 0; n < 16; n++) begin
			v = 9'($urandom);
			@(posedge clk_sys);
			host_link_ok <= v[8];
			fuse_blown <= v[7];
			out_supply_lost <= v[6];
			en_n <= v[5:4];
			pre_n <= v[3:2];
			ores_n <= v[1:0];
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			check("indicators", {8'h00, v[8], v[7] | v[6], ~v[4], ~v[2],
				~v[0], ~v[5], ~v[3], ~v[1]}, {8'h00, ind});
			check("count lamps", {14'h0000, cnt}, {14'h0000, cnt_ind});
		end
		final_report();
	end
endmodule // rate_sample_counter_cmd_bench
